/* rtl/ascs_pkg.sv */
// Shared constants, state types and helpers of the asynchronous serial controller.
package ascs_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_BAUD_HIGH = 8'hC0;
	localparam logic [7:0] OFF_BAUD_LOW = 8'hC1;
	localparam logic [7:0] OFF_CTRL_ONE = 8'hC2;
	localparam logic [7:0] OFF_CTRL_TWO = 8'hC3;
	localparam logic [7:0] OFF_STAT_ONE = 8'hC4;
	localparam logic [7:0] OFF_STAT_TWO = 8'hC5;
	localparam logic [7:0] OFF_DATA_HIGH = 8'hC6;
	localparam logic [7:0] OFF_DATA_LOW = 8'hC7;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	// Control one.
	localparam int B_NINE_BIT = 4;
	localparam int B_QUIET_LONG = 2;
	localparam int B_PARITY_ON = 1;
	localparam int B_PARITY_ODD = 0;
	// Control two.
	localparam int B_TX_EMPTY_IE = 7;
	localparam int B_TX_DONE_IE = 6;
	localparam int B_RX_IE = 5;
	localparam int B_QUIET_IE = 4;
	localparam int B_TX_ON = 3;
	localparam int B_RX_ON = 2;
	localparam int B_RX_SLEEP = 1;
	localparam int B_BREAK = 0;
	// Status two and data high.
	localparam int B_HALT_WAIT = 7;
	localparam int B_RX_ACTIVE = 0;
	localparam int B_RX_NINTH = 7;
	localparam int B_TX_NINTH = 6;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [12:0] DIVISOR_RST = 13'h0000;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	// Receive sample phases hold (phase number - 1): phases 8, 9 and 10 are mid-bit.
	localparam logic [3:0] PHASE_SAMPLE_A = 4'h7;
	localparam logic [3:0] PHASE_SAMPLE_B = 4'h8;
	localparam logic [3:0] PHASE_DECIDE = 4'h9;
	localparam logic [3:0] FRAME_LEN_EIGHT = 4'hA;
	localparam logic [3:0] FRAME_LEN_NINE = 4'hB;

	// Receiver front-end states.
	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10
	} ascs_rx_state_e;

	// Parity bit that completes the given ones count to even (odd = 0) or odd (odd = 1).
	function automatic logic parityBit(input logic [8:0] data, input logic odd);
		parityBit = (^data) ^ odd;
	endfunction

endpackage

/* rtl/ascs_sync2.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/10ps
module ascs_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// Refuse a width that makes no vector.
	if (WIDTH < 1) begin : g_bad
		$error("ascs_sync2: WIDTH must be at least one");
	end

	// First stage, read only by the second stage.
	logic [WIDTH-1:0] stageOne;

	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	// Both stages reset to the idle level so the receiver sees a quiet line.
	always_ff @(posedge mclk) begin
		if (rst) begin
			stageOne <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			stageOne <= asyncIn;
			syncOut <= stageOne;
		end
	end

endmodule

/* rtl/ascs_baud_gen.sv */
// Modulus counter that makes the sixteen-times-baud sample tick.
`timescale 1ns/10ps
module ascs_baud_gen #(
	parameter int DIV_W = 13
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic run,
	output logic tick
);

	// The counter must hold at least a divide-by-two.
	if (DIV_W < 2) begin : g_bad
		$error("ascs_baud_gen: DIV_W must be at least two");
	end

	// Cycles counted since the last tick.
	logic [DIV_W-1:0] count;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// A zero divisor or a stopped run clears the counter, so no tick leaves.
	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!run || divisor == '0) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count >= divisor - 1'b1) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

/* rtl/ascs_top.sv */
// Asynchronous serial transceiver: registers, transmitter, receiver and flag logic.
// Function
// - Short idle mode counts ones after start.
// - Long idle mode counts only after stop.
// - Parity generated and checked, even or odd.
// - Enabled flags request the interrupt.
// - Receiver activity in wait requests interrupt.
// - Transmit enable drives pin, queues preamble.
// - Sleep mutes receiver; wake clears it.
// - Break sends zeros; pulse gives one frame.
// - Break finishes current zero frame first.
// - Receive flags cleared by status-then-data read.
// - Transmit flags cleared by status-then-data write.
// - Done flag shows transmitter idle.
// - Buffer-full set when character lands.
// - Idle flag after 10/11 ones, not asleep.
// - Idle flag rearms only after buffer-full.
// - Overrun blocks transfers until cleared.
// - Noise flag with buffer-full, never on overrun.
// - Framing and parity errors flagged.
// - Halt-in-wait stops the baud clock.
// - Activity flag set at phase one, cleared on idle/false start.
// - Ninth bits received and sent, sticky.
// - Eight or nine data bits selectable.
// - LSB first, low start, high stop.
// - Baud = clock / (16 x divisor), low byte loads.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module ascs_top
	import ascs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ascs_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdata,
	input wire logic rxPin,
	output logic txPin,
	output logic txPinOeN,
	input wire logic waitMode,
	input wire logic pllSupplyLevel,
	output logic irqReq
);
	import ascs_pkg::*;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] ctrlOne_reg; // Format, idle type and parity selection.
	logic [7:0] ctrlTwo_reg; // Enables, sleep and break.
	logic [12:0] divisor_reg; // Active baud divisor.
	logic [4:0] divHigh_reg; // High divisor bits waiting for the low byte.
	logic haltInWait_reg; // Stop the baud clock in wait mode.
	logic txNinth_reg; // Ninth bit sent with every nine-bit frame while parity is off.
	logic [7:0] txData_reg; // Transmit buffer.
	logic txBufValid_reg; // Transmit buffer holds a character to send.
	logic baudEnabled_reg; // Set once either direction has been enabled.

	// Status flags.
	logic txEmpty_reg;
	logic txDone_reg;
	logic rxFull_reg;
	logic quiet_reg;
	logic overrun_reg;
	logic noise_reg;
	logic frameErr_reg;
	logic parityErr_reg;
	logic rxActive_reg;
	logic [7:0] rxData_reg; // Receive data register.
	logic rxNinth_reg; // Received ninth bit.

	// Acknowledge-sequence bookkeeping.
	logic [5:0] rxSnap_reg; // Receive flags seen at the last status read.
	logic txArm_reg; // Status read seen with a transmit flag set.
	logic quietArmed_reg; // Idle flag may set again.

	// Decoded control bits.
	logic nineBit, quietLong, parityOn, parityOdd, txOn, rxOn, rxSleep, breakSend;
	assign nineBit = ctrlOne_reg[B_NINE_BIT];
	assign quietLong = ctrlOne_reg[B_QUIET_LONG];
	assign parityOn = ctrlOne_reg[B_PARITY_ON];
	assign parityOdd = ctrlOne_reg[B_PARITY_ODD];
	assign txOn = ctrlTwo_reg[B_TX_ON];
	assign rxOn = ctrlTwo_reg[B_RX_ON];
	assign rxSleep = ctrlTwo_reg[B_RX_SLEEP];
	assign breakSend = ctrlTwo_reg[B_BREAK];

	// Bus strobes per register.
	logic wrCtrlTwo, rdStatOne, rdDataLow, wrDataLow;
	assign wrCtrlTwo = wrStb && addr == OFF_CTRL_TWO;
	assign rdStatOne = rdStb && addr == OFF_STAT_ONE;
	assign rdDataLow = rdStb && addr == OFF_DATA_LOW;
	assign wrDataLow = wrStb && addr == OFF_DATA_LOW;

	// Frame length in bits, start and stop included.
	logic [3:0] frameLen;
	assign frameLen = nineBit ? FRAME_LEN_NINE : FRAME_LEN_EIGHT;

	// ----------------------------------------
	// Clocking and input synchronisers
	// ----------------------------------------
	logic rxLine, pllLevel, baudTick, baudRun;

	ascs_sync2 #(.WIDTH(2), .RESET_VAL(2'b11)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.asyncIn({rxPin, pllSupplyLevel}),
		.syncOut({rxLine, pllLevel})
	);

	assign baudRun = baudEnabled_reg && !(haltInWait_reg && waitMode);

	ascs_baud_gen #(.DIV_W(13)) u_baud (
		.mclk(mclk),
		.rst(rst),
		.divisor(divisor_reg),
		.run(baudRun),
		.tick(baudTick)
	);

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// The divisor only changes on the low byte, so a half-written value never runs.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlOne_reg <= CTRL_ONE_RST;
			divisor_reg <= DIVISOR_RST;
			divHigh_reg <= '0;
			haltInWait_reg <= 1'b0;
			txNinth_reg <= 1'b0;
			baudEnabled_reg <= 1'b0;
		end else begin
			if (wrStb && addr == OFF_CTRL_ONE) begin
				ctrlOne_reg <= wdata;
			end
			if (wrStb && addr == OFF_BAUD_HIGH) begin
				divHigh_reg <= wdata[4:0];
			end
			if (wrStb && addr == OFF_BAUD_LOW) begin
				divisor_reg <= {divHigh_reg, wdata};
			end
			if (wrStb && addr == OFF_STAT_TWO) begin
				haltInWait_reg <= wdata[B_HALT_WAIT];
			end
			if (wrStb && addr == OFF_DATA_HIGH) begin
				txNinth_reg <= wdata[B_TX_NINTH];
			end
			if (txOn || rxOn) begin
				baudEnabled_reg <= 1'b1;
			end
		end
	end

	// Receiver wake comes from the idle detector below.
	logic quietHit;

	// Control two; hardware clears the sleep bit on wake.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlTwo_reg <= CTRL_TWO_RST;
		end else if (wrCtrlTwo) begin
			ctrlTwo_reg <= wdata;
		end else if (quietHit && rxSleep) begin
			ctrlTwo_reg[B_RX_SLEEP] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	logic [3:0] txPhase; // Sample ticks within the current bit.
	logic [9:0] txShift; // Bits still to send, LSB first.
	logic [3:0] txLeft; // Bits still in txShift.
	logic txBusy; // A frame is on the line.
	logic preamblePend; // Idle frame queued by enabling the transmitter.
	logic breakLatch; // Break requested, not yet started.
	logic txBitEdge, breakReq, txLoadData;
	logic [10:0] dataFrame;
	logic [7:0] txChar;
	logic txNinthBit;

	assign txBitEdge = txOn && baudTick && txPhase == PHASE_LAST;
	assign breakReq = breakSend || breakLatch;
	assign txLoadData = txBitEdge && txLeft == '0 && !breakReq && !preamblePend && txBufValid_reg;

	// transmit parity replaces the top data bit
	always_comb begin
		txChar = txData_reg;
		txNinthBit = txNinth_reg;
		if (parityOn && nineBit) begin
			txNinthBit = parityBit({1'b0, txData_reg}, parityOdd);
		end else if (parityOn) begin
			txChar[7] = parityBit({2'b00, txData_reg[6:0]}, parityOdd);
		end
	end

	// stop, data, start; ninth before stop
	assign dataFrame = nineBit ? {1'b1, txNinthBit, txChar, 1'b0} : {2'b11, txChar, 1'b0};

	// Bit sequencer: a new frame is chosen only at a bit edge with nothing left.
	// Break outranks the preamble, which outranks data.
	always_ff @(posedge mclk) begin
		if (rst || !txOn) begin
			txPhase <= '0;
			txShift <= '1;
			txLeft <= '0;
			txBusy <= 1'b0;
			txPin <= 1'b1;
		end else if (baudTick) begin
			txPhase <= txPhase + 1'b1;
			if (txBitEdge && txLeft != '0) begin
				txPin <= txShift[0];
				txShift <= {1'b1, txShift[9:1]};
				txLeft <= txLeft - 1'b1;
			end else if (txBitEdge) begin
				// break ends only on a frame boundary
				if (breakReq) begin
					txPin <= 1'b0;
					txShift <= '0;
					txLeft <= frameLen - 1'b1;
					txBusy <= 1'b1;
				end else if (preamblePend) begin
					txPin <= 1'b1;
					txShift <= '1;
					txLeft <= frameLen - 1'b1;
					txBusy <= 1'b1;
				end else if (txBufValid_reg) begin
					txPin <= dataFrame[0];
					txShift <= dataFrame[10:1];
					txLeft <= frameLen - 1'b1;
					txBusy <= 1'b1;
				end else begin
					txPin <= 1'b1;
					txBusy <= 1'b0;
				end
			end
		end
	end

	// Pin ownership and the queued preamble and break requests.
	always_ff @(posedge mclk) begin
		if (rst) begin
			txPinOeN <= 1'b1;
			preamblePend <= 1'b0;
			breakLatch <= 1'b0;
		end else begin
			txPinOeN <= !txOn;
			if (wrCtrlTwo && wdata[B_TX_ON] && !txOn) begin
				preamblePend <= 1'b1;
			end else if (txBitEdge && txLeft == '0 && !breakReq) begin
				preamblePend <= 1'b0;
			end
			// short pulse still gives one frame
			if (wrCtrlTwo && wdata[B_BREAK]) begin
				breakLatch <= 1'b1;
			end else if (txBitEdge && txLeft == '0 || !txOn) begin
				breakLatch <= 1'b0;
			end
		end
	end

	// Transmit buffer and its flags; a set beats a clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (rst) begin
			txData_reg <= '0;
			txBufValid_reg <= 1'b0;
			txEmpty_reg <= 1'b1;
			txDone_reg <= 1'b1;
			txArm_reg <= 1'b0;
		end else begin
			if (rdStatOne) begin
				txArm_reg <= txEmpty_reg || txDone_reg;
			end else if (wrDataLow) begin
				txArm_reg <= 1'b0;
			end
			// write without status read is dropped
			if (wrDataLow && txArm_reg) begin
				txData_reg <= wdata;
				txBufValid_reg <= 1'b1;
			end else if (txLoadData) begin
				txBufValid_reg <= 1'b0;
			end
			if (txLoadData) begin
				txEmpty_reg <= 1'b1;
			end else if (wrDataLow && txArm_reg) begin
				// clear by status read then data write
				txEmpty_reg <= 1'b0;
			end
			// done while nothing is sent or queued
			if (!txBusy && !txBufValid_reg && !preamblePend && !breakReq) begin
				txDone_reg <= 1'b1;
			end else if (wrDataLow && txArm_reg || txBusy) begin
				txDone_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Receiver front end
	// ----------------------------------------
	ascs_rx_state_e rxState;
	logic [3:0] rxPhase; // Sample phase within the bit, phase one is zero.
	logic [3:0] rxBitIdx; // Bit after the start bit being received.
	logic [1:0] rxSmp; // Earlier mid-bit samples.
	logic [8:0] rxFrame; // Assembled data bits.
	logic rxNoiseAcc; // Samples disagreed somewhere in the frame.
	logic [3:0] onesCount; // Consecutive ones in bit times.
	logic rxDecide, rxMaj, rxDisagree, huntBit, isStop, frameEnd, parityBad;

	assign rxMaj = (rxSmp[1] & rxSmp[0]) | (rxSmp[1] & rxLine) | (rxSmp[0] & rxLine);
	assign rxDisagree = !(rxSmp[1] == rxSmp[0] && rxSmp[0] == rxLine);
	assign rxDecide = rxOn && baudTick && rxState != RX_HUNT && rxPhase == PHASE_DECIDE;
	assign isStop = rxState == RX_DATA && rxBitIdx == frameLen - 4'h2;
	assign frameEnd = rxDecide && isStop;
	assign huntBit = rxOn && baudTick && rxState == RX_HUNT && rxLine && rxPhase == PHASE_LAST;
	// received ones plus parity must match the type
	assign parityBad = nineBit ? (parityBit(rxFrame, parityOdd) != 1'b0) :
		(parityBit({1'b0, rxFrame[7:0]}, parityOdd) != 1'b0);

	// Bit timing: search for a falling edge, check the start bit, then collect bits.
	always_ff @(posedge mclk) begin
		if (rst || !rxOn) begin
			rxState <= RX_HUNT;
			rxPhase <= '0;
			rxBitIdx <= '0;
			rxSmp <= '0;
			rxFrame <= '0;
			rxNoiseAcc <= 1'b0;
		end else if (baudTick) begin
			rxPhase <= rxPhase + 1'b1;
			if (rxPhase == PHASE_SAMPLE_A || rxPhase == PHASE_SAMPLE_B) begin
				rxSmp <= {rxSmp[0], rxLine};
			end
			unique case (rxState)
				RX_HUNT: begin
					if (!rxLine) begin
						rxState <= RX_START;
						rxPhase <= 4'h1;
						rxNoiseAcc <= 1'b0;
					end
				end
				RX_START: begin
					if (rxDecide && rxMaj) begin
						rxState <= RX_HUNT;
						rxPhase <= '0;
					end else if (rxDecide) begin
						rxNoiseAcc <= rxDisagree;
					end else if (rxPhase == PHASE_LAST) begin
						rxState <= RX_DATA;
						rxBitIdx <= '0;
					end
				end
				RX_DATA: begin
					if (rxDecide) begin
						rxNoiseAcc <= rxNoiseAcc | rxDisagree;
						if (!isStop) begin
							rxFrame[rxBitIdx] <= rxMaj;
						end else begin
							rxState <= RX_HUNT;
							rxPhase <= '0;
						end
					end else if (rxPhase == PHASE_LAST) begin
						rxBitIdx <= rxBitIdx + 1'b1;
					end
				end
				default: begin
					rxState <= RX_HUNT;
				end
			endcase
		end
	end

	// Idle-line counter of whole bit times at one.
	assign quietHit = huntBit && onesCount == frameLen - 1'b1;
	always_ff @(posedge mclk) begin
		if (rst || !rxOn) begin
			onesCount <= '0;
		end else if (rxDecide) begin
			if (rxState == RX_START || !rxMaj) begin
				onesCount <= '0;
			end else if (isStop && quietLong) begin
				// long mode starts at the stop bit
				onesCount <= 4'h1;
			end else if (!quietLong && onesCount < frameLen) begin
				// short mode counts every one after start
				onesCount <= onesCount + 1'b1;
			end else if (!isStop) begin
				onesCount <= '0;
			end
		end else if (huntBit && onesCount < frameLen) begin
			onesCount <= onesCount + 1'b1;
		end
	end

	// Receiver activity flag.
	always_ff @(posedge mclk) begin
		if (rst || !rxOn) begin
			rxActive_reg <= 1'b0;
		end else if (baudTick && rxState == RX_HUNT && !rxLine) begin
			// set at phase one of the search
			rxActive_reg <= 1'b1;
		end else if (quietHit || rxDecide && rxState == RX_START && rxMaj) begin
			// cleared on idle or false start
			rxActive_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Receive flags
	// ----------------------------------------
	logic rxTransfer, rxOverrunEvt;
	logic [5:0] rxClr;
	assign rxTransfer = frameEnd && !rxSleep && !rxFull_reg && !overrun_reg;
	assign rxOverrunEvt = frameEnd && !rxSleep && rxFull_reg;
	// only flags seen at the status read clear
	assign rxClr = (rdDataLow) ? rxSnap_reg : 6'b000000;

	// Each flag: hardware set wins over the acknowledge clear.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxFull_reg <= 1'b0;
			quiet_reg <= 1'b0;
			overrun_reg <= 1'b0;
			noise_reg <= 1'b0;
			frameErr_reg <= 1'b0;
			parityErr_reg <= 1'b0;
			rxData_reg <= '0;
			rxNinth_reg <= 1'b0;
			rxSnap_reg <= '0;
			quietArmed_reg <= 1'b0;
		end else begin
			if (rdStatOne) begin
				rxSnap_reg <= {rxFull_reg, quiet_reg, overrun_reg, noise_reg, frameErr_reg, parityErr_reg};
			end else if (rdDataLow) begin
				rxSnap_reg <= '0;
			end
			if (rxTransfer) begin
				rxFull_reg <= 1'b1;
				rxData_reg <= rxFrame[7:0];
				rxNinth_reg <= rxFrame[8];
				noise_reg <= rxNoiseAcc | rxDisagree;
				frameErr_reg <= !rxMaj;
				parityErr_reg <= parityOn && parityBad;
			end else begin
				rxFull_reg <= rxFull_reg & ~rxClr[5];
				noise_reg <= noise_reg & ~rxClr[2];
				frameErr_reg <= frameErr_reg & ~rxClr[1];
				parityErr_reg <= parityErr_reg & ~rxClr[0];
			end
			overrun_reg <= rxOverrunEvt | (overrun_reg & ~rxClr[3]);
			if (rxTransfer) begin
				quietArmed_reg <= 1'b1;
			end else if (quietHit && !rxSleep) begin
				quietArmed_reg <= 1'b0;
			end
			quiet_reg <= (quietHit && !rxSleep && quietArmed_reg) | (quiet_reg & ~rxClr[4]);
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// A sleeping receiver raises no full, overrun or activity request; a held idle flag and the transmit side still may.
	always_ff @(posedge mclk) begin
		if (rst) begin
			irqReq <= 1'b0;
		end else begin
			// activity during wait with supply present
			irqReq <= (ctrlTwo_reg[B_TX_EMPTY_IE] && txEmpty_reg) || (ctrlTwo_reg[B_TX_DONE_IE] && txDone_reg) ||
				(ctrlTwo_reg[B_RX_IE] && !rxSleep && (rxFull_reg || overrun_reg)) ||
				(ctrlTwo_reg[B_QUIET_IE] && quiet_reg) ||
				(ctrlTwo_reg[B_RX_IE] && !rxSleep && waitMode && pllLevel && rxActive_reg);
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [7:0] readMux;
	// Unmapped addresses read as zero; status one writes are ignored.
	// status register has no write path
	always_comb begin
		unique case (addr)
			OFF_BAUD_HIGH: readMux = {3'b000, divisor_reg[12:8]};
			OFF_BAUD_LOW: readMux = divisor_reg[7:0];
			OFF_CTRL_ONE: readMux = ctrlOne_reg;
			OFF_CTRL_TWO: readMux = ctrlTwo_reg;
			OFF_STAT_ONE: readMux = {txEmpty_reg, txDone_reg, rxFull_reg, quiet_reg,
				overrun_reg, noise_reg, frameErr_reg, parityErr_reg};
			OFF_STAT_TWO: readMux = {haltInWait_reg, 6'b000000, rxActive_reg};
			OFF_DATA_HIGH: readMux = {rxNinth_reg, txNinth_reg, 6'b000000};
			OFF_DATA_LOW: readMux = rxData_reg;
			default: readMux = 8'h00;
		endcase
	end

	// Data stand for exactly the cycle after the read strobe.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdStb ? readMux : 8'h00;
		end
	end

endmodule

/* tb/ascs_top_asserts.sv */
// Port assertions for the serial controller, bound into its top.
`timescale 1ns/10ps
module ascs_chk
	import ascs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ascs_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] rdata,
	input wire logic txPin,
	input wire logic txPinOeN,
	input wire logic irqReq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Shadow of control two, so enables can be predicted from the bus.
	logic [7:0] ctl;
	always_ff @(posedge mclk) ctl <= rst ? 8'h00 : (wrStb && addr == OFF_CTRL_TWO) ? wdata : ctl;
	// Set by the first transmit data write; until then, with the transmitter off, both transmit flags must read as set.
	logic dataWr;
	always_ff @(posedge mclk) dataWr <= rst ? 1'b0 : dataWr | (wrStb && addr == OFF_DATA_LOW);
	a_oe_track: assert property (!$past(rst) |-> txPinOeN == !$past(ctl[B_TX_ON]))
		else $error("pin enable does not follow transmit enable");
	a_reset_vals: assert property (disable iff (1'b0) rst && $past(rst) |=> txPin && txPinOeN && !irqReq)
		else $error("outputs not idle in reset");
	a_irq_masked: assert property (ctl[7:4] == 4'h0 && $past(ctl[7:4]) == 4'h0 |-> !irqReq)
		else $error("interrupt with all enables off");
	a_tx_quiet: assert property (txPinOeN |-> txPin)
		else $error("undriven transmit pin not idle high");
	a_rdata_idle: assert property (!$past(rdStb) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property ($past(rdStb) && ($past(addr) < OFF_BAUD_HIGH || $past(addr) > OFF_DATA_LOW)
		|-> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_tx_flags: assert property ($past(rdStb) && $past(addr) == OFF_STAT_ONE && !$past(ctl[B_TX_ON])
		&& !$past(dataWr) |-> rdata[7:6] == 2'b11)
		else $error("transmit flags clear while disabled");
	a_ctl_back: assert property ($past(rdStb) && $past(addr) == OFF_CTRL_TWO |-> rdata[7:2] == $past(ctl[7:2]))
		else $error("control two readback wrong");
	c_irq: cover property (irqReq);
	c_rx_read: cover property ($past(rdStb) && $past(addr) == OFF_DATA_LOW);
	c_tx_start: cover property ($fell(txPin));
endmodule
bind ascs_top ascs_chk ascs_chk_i (.mclk, .rst, .addr, .wdata, .wrStb, .rdStb, .rdata, .txPin, .txPinOeN, .irqReq);

/* tb/ascs_remote.sv */
// Remote serial node that sends frames into the receive pin.
`timescale 1ns/10ps
module ascs_remote (
	input wire logic mclk,
	input wire logic txPin,
	output logic rxPin = 1'b1
);
	// Start low, eight bits LSB first, stop high; 16 clocks a bit at divisor one.
	task automatic send(input logic [7:0] v);
		for (int k = 0; k < 10; k++) begin
			rxPin <= 1'(({1'b1, v, 1'b0}) >> k);
			repeat (16) @(posedge mclk);
		end
	endtask
	// Listens on the transmit pin: bounded wait for the start edge, then mid-bit samples.
	// A start that never comes leaves a one in v[0], which the bench sees as a bad frame.
	task automatic recv(output logic [9:0] v);
		int k;
		v = '0;
		for (k = 0; k < 1000 && txPin !== 1'b0; k++) @(negedge mclk);
		repeat (8) @(negedge mclk);
		v[0] = txPin;
		for (k = 1; k < 10; k++) begin
			repeat (16) @(negedge mclk);
			v[k] = txPin;
		end
	endtask
endmodule

/* tb/tb_ascs_top.sv */
// Self-checking bench for the serial controller.
`timescale 1ns/10ps
module tb_ascs_top;
	import ascs_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rdPend = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
	logic txPin, txPinOeN, irqReq, rxPin;
	logic waitMode = 1'b0, pllSupplyLevel = 1'b1;
	logic [9:0] f;
	logic [7:0] q[$];
	int miscompares = 0, compares = 0, n;
	ascs_top ascs_top_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb),
		.rdata(rdata), .rxPin(rxPin), .txPin(txPin), .txPinOeN(txPinOeN), .waitMode(waitMode),
		.pllSupplyLevel(pllSupplyLevel), .irqReq(irqReq));
	ascs_remote ascs_remote_i (.mclk(mclk), .txPin(txPin), .rxPin(rxPin));
	initial forever #2.5 mclk = ~mclk;
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Read data stands one cycle only, so it is matched at that edge.
	always @(posedge mclk) begin
		rdPend <= rdStb;
		if (rdPend) begin
			chk("rdata", rdata, q.pop_front());
		end
	end
	// One bus cycle; a read notes its expected data first.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wrStb <= w;
		rdStb <= !w;
		if (!w) q.push_back(v);
		@(posedge mclk);
		wrStb <= 1'b0;
		rdStb <= 1'b0;
	endtask
	initial begin
		r = $urandom(32'h0BD2);
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		acc(1'b1, OFF_STAT_ONE, 8'h00);
		acc(1'b0, OFF_STAT_ONE, 8'hC0);
		acc(1'b0, 8'h10, 8'h00);
		acc(1'b1, OFF_BAUD_LOW, 8'h01);
		acc(1'b1, OFF_CTRL_TWO, 8'h8C);
		acc(1'b0, OFF_CTRL_TWO, 8'h8C);
		@(negedge mclk);
		chk("irqReq", {7'h00, irqReq}, 8'h01);
		repeat (20) @(posedge mclk);
		acc(1'b0, OFF_STAT_ONE, 8'h80);
		acc(1'b1, OFF_DATA_HIGH, 8'h40);
		acc(1'b0, OFF_DATA_HIGH, 8'h40);
		acc(1'b1, OFF_DATA_LOW, r);
		repeat (2) @(negedge mclk);
		chk("irqReq", {7'h00, irqReq}, 8'h00);
		// The preamble is all ones, so the first falling edge is the data frame.
		ascs_remote_i.recv(f);
		chk("txData", f[8:1], r);
		chk("txFrame", {6'h00, f[9], f[0]}, 8'h02);
		// Single frame, overrun pair, then even and odd parity; 400 clocks cover the idle count.
		for (n = 0; n < 4; n++) begin
			r = (n > 1) ? 8'h01 : 8'($urandom);
			acc(1'b1, OFF_CTRL_ONE, {6'h00, n > 1, n == 3});
			repeat ((n == 1) ? 2 : 1) ascs_remote_i.send(r);
			repeat (400) @(posedge mclk);
			acc(1'b0, OFF_STAT_ONE, {4'hF, n == 1, 2'b00, n == 2});
			acc(1'b0, OFF_DATA_LOW, r);
			acc(1'b0, OFF_STAT_ONE, 8'hC0);
		end
		// Activity in wait mode requests an interrupt only with the supply present.
		waitMode <= 1'b1;
		pllSupplyLevel <= 1'b0;
		acc(1'b1, OFF_CTRL_TWO, 8'h2C);
		fork
			ascs_remote_i.send(8'hFF);
		join_none
		repeat (40) @(negedge mclk);
		chk("irqReq", {7'h00, irqReq}, 8'h00);
		@(posedge mclk);
		pllSupplyLevel <= 1'b1;
		repeat (8) @(negedge mclk);
		chk("irqReq", {7'h00, irqReq}, 8'h01);
		repeat (200) @(posedge mclk);
		print_verdict();
	end
endmodule
